//--- design/ptpfr_pkg.sv
// Shared constants and types for the timing frame rewrite block
package ptpfr_pkg;

	////////////////////////////////////////////////////////////////////
	// Action field layout
	localparam int ACT_W = 8;
	localparam int ACT_STAMP_LO = 0;
	localparam int ACT_DELAY_LO = 2;
	localparam int ACT_SEQ_LO = 4;
	localparam int ACT_SMAC_TO_DMAC = 6;
	localparam int ACT_CFG_SMAC = 7;

	typedef enum logic [1:0] {
		STAMP_NONE = 2'h0,
		STAMP_ONE = 2'h1,
		STAMP_TWO = 2'h2,
		STAMP_TOD = 2'h3
	} ptpfr_stamp_t;

	typedef enum logic [1:0] {
		DLY_NONE = 2'h0,
		DLY_EGRESS = 2'h1,
		DLY_INGRESS_ONE = 2'h2,
		DLY_INGRESS_TWO = 2'h3
	} ptpfr_delay_t;

	localparam logic [1:0] SEQ_CMD_NONE = 2'h0;
	localparam logic [1:0] SEQ_CMD_UPDATE = 2'h1;

	////////////////////////////////////////////////////////////////////
	// Domains, widths and reset values
	localparam int NUM_DOMAINS = 3;
	localparam logic [1:0] DOMAIN_RST = 2'h0;
	localparam logic [1:0] DOMAIN_LAST = 2'h2;
	localparam int SEQ_ENTRIES = 256;
	localparam int SEQ_IDX_W = 8;
	localparam int CORR_W = 48;
	localparam int MAC_W = 48;
	localparam int STAMP_W = 32;
	localparam logic [CORR_W-1:0] CORR_SAT = 48'h7fffffffffff;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_MARGIN = 4;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_INGRESS = 2'b10
	} ptpfr_state_t;

endpackage : ptpfr_pkg

//--- design/ptpfr_fifo.sv
// Small synchronous FIFO holding two-step stamp entries
`timescale 1ns/100ps
module ptpfr_fifo #(
	parameter int W = 37, // Entry width
	parameter int DEPTH = 8 // Entry count, power of two
)
(
	input wire logic clock, // Core clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic in_valid, // Push request
	output logic in_ready, // Room for one entry
	input wire logic [W-1:0] in_data, // Pushed entry
	output logic out_valid, // Entry available
	input wire logic out_ready, // Pop request
	output logic [W-1:0] out_data, // Oldest entry
	output logic [$clog2(DEPTH):0] level // Entries held
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic push;
	logic pop;

	// Handshakes; full and empty come from the exact count
	assign in_ready = (level != (AW+1)'(DEPTH));
	assign out_valid = (level != '0);
	assign push = in_valid && in_ready;
	assign pop = out_ready && out_valid;
	assign out_data = mem[rptr];

	////////////////////////////////////////////////////////////////////
	// Storage, no reset needed since empty entries are never read
	always_ff @(posedge clock)
	begin
		if (push)
			mem[wptr] <= in_data;
	end

	// Pointers wrap naturally because depth is a power of two
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			wptr <= '0;
			rptr <= '0;
			level <= '0;
		end
		else
		begin
			if (push)
				wptr <= wptr + 1'b1;
			if (pop)
				rptr <= rptr + 1'b1;
			if (push && !pop)
				level <= level + 1'b1;
			else if (pop && !push)
				level <= level - 1'b1;
		end
	end

endmodule : ptpfr_fifo

//--- design/ptpfr_rewrite.sv
// Per-frame timing protocol rewrite control with two-step stamp queue
`timescale 1ns/100ps
module ptpfr_rewrite
	import ptpfr_pkg::*;
#(
	parameter int NP = 11, // Physical ports; any index NP or above is the CPU port
	parameter int PW = 4, // Port number width
	parameter int DW = 16, // Delay value width
	parameter int SW = 16 // Sequence number width
)
(
	input wire logic clock, // Core clock, 40 MHz
	input wire logic sys_rst, // Synchronous reset, active high
	// Frame descriptor in
	input wire logic in_valid, // Descriptor offered
	output logic in_ready, // Descriptor accepted when high
	input wire logic [ACT_W-1:0] in_action, // Analyzer action field
	input wire logic [PW-1:0] in_rx_port, // Receive port
	input wire logic [PW-1:0] in_tx_port, // Transmit port
	input wire logic [SEQ_IDX_W-1:0] in_hdr_stamp, // Header stamp low bits
	input wire logic [MAC_W-1:0] in_src_mac, // Frame source MAC
	input wire logic [MAC_W-1:0] in_dst_mac, // Frame destination MAC
	input wire logic [CORR_W-1:0] in_corr, // Incoming correction_field
	input wire logic [CORR_W-1:0] in_rx_time, // Reception time
	input wire logic [STAMP_W-1:0] in_tx_stamp, // Egress stamp
	input wire logic [STAMP_W-1:0] in_rx_stamp, // Ingress stamp
	input wire logic in_rsrv_nonzero, // Reserved bytes not zero
	input wire logic in_is_udp, // Frame carried in UDP
	input wire logic [CORR_W-1:0] tod_now, // Current time of day
	// Per-port configuration
	input wire logic [1:0] port_domain_cfg [NP], // Domain select
	input wire logic [NP-1:0] port_stamp_en, // Stamping enable
	input wire logic [NP-1:0] udp_checksum_update_cfg, // 1 disables
	input wire logic [DW-1:0] egress_path_delay [NP], // Tx delay
	input wire logic [DW-1:0] ingress_path_delay_one [NP], // Rx delay 1
	input wire logic [DW-1:0] ingress_path_delay_two [NP], // Rx delay 2
	input wire logic [MAC_W-1:0] port_timing_smac [NP], // Port SMAC
	input wire logic cpu_vp_stamp_en, // CPU port stamping enable
	input wire logic [1:0] cpu_vp_domain_cfg, // CPU port domain
	// Sticky flags and queue access
	input wire logic [NP-1:0] reserved_nonzero_clr, // Clear pulses
	input wire logic [NP-1:0] correction_overflow_clr, // Clear pulses
	input wire logic twostep_fifo_control, // Pop next entry pulse
	input wire logic seq_wr_en, // Sequence table write
	input wire logic [SEQ_IDX_W-1:0] seq_idx, // Table index
	input wire logic [SW-1:0] seq_wr_data, // Table write data
	// Outputs
	output logic [1:0] port_domain [NP], // Effective domain
	output logic [1:0] cpu_virtual_port_timing_mode, // Effective CPU port domain
	output logic [NP-1:0] reserved_nonzero_sticky, // Per rx port
	output logic [NP-1:0] correction_overflow_sticky, // Per tx port
	output logic [STAMP_W+PW:0] twostep_fifo_value, // {egr,port,stamp}
	output logic twostep_value_valid, // Value holds a real entry
	output logic [SW-1:0] seq_rd_data, // Table read data
	output logic out_valid, // Result pulse
	output logic [MAC_W-1:0] out_dst_mac, // Rewritten destination
	output logic [MAC_W-1:0] out_src_mac, // Rewritten source
	output logic [CORR_W-1:0] out_corr, // Rewritten correction
	output logic [SW-1:0] out_seq, // Inserted sequence number
	output logic out_seq_insert, // Sequence field replaced
	output logic [1:0] out_stamp_cmd, // Stamp command to port
	output logic out_tod_insert, // Origin time replaced
	output logic [CORR_W-1:0] out_origin_time, // Time of day stamp
	output logic out_auto_response, // Delay response handling
	output logic out_cksum_update, // UDP checksum to refresh
	output logic [1:0] out_domain, // Domain of tx port
	output logic [PW-1:0] out_tx_port // Transmit port
);
	localparam int EW = STAMP_W + PW + 1;

	logic take;
	ptpfr_state_t state;
	logic [PW-1:0] held_rx_port;
	logic [STAMP_W-1:0] held_rx_stamp;
	logic fifo_in_valid;
	logic [EW-1:0] fifo_in_data;
	logic fifo_out_valid;
	logic [EW-1:0] fifo_out_data;
	logic [$clog2(FIFO_DEPTH):0] fifo_level;
	logic [SW-1:0] seq_mem [SEQ_ENTRIES];
	ptpfr_stamp_t stamp_cmd;
	ptpfr_delay_t dly_cmd;
	logic [1:0] seq_cmd;
	logic tx_phys;
	logic rx_phys;
	logic tx_en;
	logic [1:0] tx_dom;
	logic [DW-1:0] add_dly;
	logic [CORR_W:0] corr_sum;
	logic corr_ovf;
	logic modified;

	assign take = in_valid && in_ready;

	////////////////////////////////////////////////////////////////////
	// Domain assignment, illegal code 3 falls back to the default
	// one domain per port
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < NP; i++)
				port_domain[i] <= DOMAIN_RST;
		end
		else
		begin
			for (int i = 0; i < NP; i++)
				port_domain[i] <= (port_domain_cfg[i] > DOMAIN_LAST) ?
					DOMAIN_RST : port_domain_cfg[i];
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			cpu_virtual_port_timing_mode <= DOMAIN_RST;
		else
			cpu_virtual_port_timing_mode <=
				(cpu_vp_domain_cfg > DOMAIN_LAST) ? DOMAIN_RST :
				cpu_vp_domain_cfg;
	end

	////////////////////////////////////////////////////////////////////
	// Action decode and per-port lookups
	// stamp command decode
	always_comb
	begin
		stamp_cmd = ptpfr_stamp_t'(in_action[ACT_STAMP_LO +: 2]);
		dly_cmd = ptpfr_delay_t'(in_action[ACT_DELAY_LO +: 2]);
		seq_cmd = in_action[ACT_SEQ_LO +: 2];
		tx_phys = (in_tx_port < PW'(NP));
		rx_phys = (in_rx_port < PW'(NP));
		tx_en = tx_phys ? port_stamp_en[in_tx_port] : cpu_vp_stamp_en;
		tx_dom = tx_phys ? port_domain[in_tx_port] :
			cpu_virtual_port_timing_mode;
		add_dly = '0;
		unique case (dly_cmd)
			DLY_NONE: add_dly = '0;
			DLY_EGRESS: add_dly = tx_phys ?
				egress_path_delay[in_tx_port] : '0;
			DLY_INGRESS_ONE: add_dly = rx_phys ?
				ingress_path_delay_one[in_rx_port] : '0;
			DLY_INGRESS_TWO: add_dly = rx_phys ?
				ingress_path_delay_two[in_rx_port] : '0;
		endcase
		// delay only when stamping
		// Two-step frames leave untouched; software adds delays later
		if (!tx_en || stamp_cmd == STAMP_TWO || stamp_cmd == STAMP_NONE)
			add_dly = '0;
	end

	// Signed sum one bit wider so the valid range can be checked
	always_comb
	begin
		corr_sum = {in_corr[CORR_W-1], in_corr} + (CORR_W+1)'(add_dly);
		corr_ovf = (corr_sum[CORR_W] != corr_sum[CORR_W-1]);
		modified = (stamp_cmd != STAMP_NONE) ||
			(seq_cmd == SEQ_CMD_UPDATE) || in_action[ACT_SMAC_TO_DMAC] ||
			in_action[ACT_CFG_SMAC];
	end

	////////////////////////////////////////////////////////////////////
	// Result stage, one cycle after acceptance
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			out_valid <= 1'b0;
		else
			out_valid <= take;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			out_dst_mac <= '0;
			out_src_mac <= '0;
			out_corr <= '0;
			out_stamp_cmd <= STAMP_NONE;
			out_tod_insert <= 1'b0;
			out_origin_time <= '0;
			out_auto_response <= 1'b0;
			out_cksum_update <= 1'b0;
			out_domain <= DOMAIN_RST;
			out_tx_port <= '0;
		end
		else if (take)
		begin
			out_dst_mac <= in_action[ACT_SMAC_TO_DMAC] ? in_src_mac :
				in_dst_mac;
			out_src_mac <= (in_action[ACT_CFG_SMAC] && tx_phys) ?
				port_timing_smac[in_tx_port] : in_src_mac;
			if (seq_cmd[1] && stamp_cmd == STAMP_ONE)
				out_corr <= in_rx_time;
			else if (corr_ovf)
				out_corr <= CORR_SAT;
			else
				out_corr <= corr_sum[CORR_W-1:0];
			out_stamp_cmd <= tx_en ? stamp_cmd : STAMP_NONE;
			out_tod_insert <= tx_en && (stamp_cmd == STAMP_TOD);
			out_origin_time <= tod_now;
			out_auto_response <= seq_cmd[1];
			out_cksum_update <= in_is_udp && modified &&
				!(tx_phys && udp_checksum_update_cfg[in_tx_port]);
			out_domain <= tx_dom;
			out_tx_port <= in_tx_port;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sequence table; a software write in the same cycle wins
	// entry chosen by stamp bits
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < SEQ_ENTRIES; i++)
				seq_mem[i] <= '0;
			out_seq <= '0;
			out_seq_insert <= 1'b0;
			seq_rd_data <= '0;
		end
		else
		begin
			out_seq_insert <= take && (seq_cmd == SEQ_CMD_UPDATE);
			if (take && seq_cmd == SEQ_CMD_UPDATE)
			begin
				out_seq <= seq_mem[in_hdr_stamp];
				seq_mem[in_hdr_stamp] <= seq_mem[in_hdr_stamp] + 1'b1;
			end
			if (seq_wr_en)
				seq_mem[seq_idx] <= seq_wr_data;
			seq_rd_data <= seq_mem[seq_idx];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sticky flags; a set in the clearing cycle is kept
	generate
		for (genvar p = 0; p < NP; p++)
		begin : g_sticky
			always_ff @(posedge clock)
			begin
				if (sys_rst)
					reserved_nonzero_sticky[p] <= 1'b0;
				else if (take && in_rsrv_nonzero && in_rx_port == PW'(p))
					reserved_nonzero_sticky[p] <= 1'b1;
				else if (reserved_nonzero_clr[p])
					reserved_nonzero_sticky[p] <= 1'b0;
			end
			always_ff @(posedge clock)
			begin
				if (sys_rst)
					correction_overflow_sticky[p] <= 1'b0;
				else if (take && corr_ovf && in_tx_port == PW'(p) &&
					!(seq_cmd[1] && stamp_cmd == STAMP_ONE))
					correction_overflow_sticky[p] <= 1'b1;
				else if (correction_overflow_clr[p])
					correction_overflow_sticky[p] <= 1'b0;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Two-step queue: egress entry on acceptance, ingress entry next
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			state <= ST_IDLE;
			held_rx_port <= '0;
			held_rx_stamp <= '0;
		end
		else
		begin
			unique case (state)
				ST_IDLE:
				begin
					if (take && stamp_cmd == STAMP_TWO)
					begin
						state <= ST_INGRESS;
						held_rx_port <= in_rx_port;
						held_rx_stamp <= in_rx_stamp;
					end
				end
				ST_INGRESS:
					state <= ST_IDLE;
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// Entry word is {egress flag, port, stamp}
	always_comb
	begin
		fifo_in_valid = 1'b0;
		fifo_in_data = {1'b1, in_tx_port, in_tx_stamp};
		if (state == ST_INGRESS)
		begin
			fifo_in_valid = 1'b1;
			fifo_in_data = {1'b0, held_rx_port, held_rx_stamp};
		end
		else if (take && stamp_cmd == STAMP_TWO)
			fifo_in_valid = 1'b1;
	end

	// Acceptance stalls unless two entries surely fit; level is a
	// cycle old, hence the wider margin instead of a tighter count
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			in_ready <= 1'b0;
		else
			in_ready <= (state == ST_IDLE) &&
				!(take && stamp_cmd == STAMP_TWO) &&
				(fifo_level <= ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH -
				FIFO_MARGIN));
	end

	ptpfr_fifo #(
		.W(EW),
		.DEPTH(FIFO_DEPTH)
	) u_stamp_fifo (
		.clock(clock),
		.sys_rst(sys_rst),
		.in_valid(fifo_in_valid),
		.in_ready(),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(twostep_fifo_control),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			twostep_fifo_value <= '0;
			twostep_value_valid <= 1'b0;
		end
		else if (twostep_fifo_control)
		begin
			twostep_fifo_value <= fifo_out_valid ? fifo_out_data : '0;
			twostep_value_valid <= fifo_out_valid;
		end
	end

endmodule : ptpfr_rewrite

//--- dv/ptpfr_rewrite_sva.sv
// Concurrent checks on the rewrite block ports
`timescale 1ns/100ps
module ptpfr_rewrite_sva
	import ptpfr_pkg::*;
#(
	parameter int NP = 11, // Physical ports
	parameter int PW = 4 // Port number width
)
(
	input wire logic clock, // Core clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic in_valid, // Descriptor offered
	input wire logic in_ready, // Descriptor accepted
	input wire logic [ACT_W-1:0] in_action, // Action field
	input wire logic [PW-1:0] in_rx_port, // Receive port
	input wire logic [PW-1:0] in_tx_port, // Transmit port
	input wire logic [MAC_W-1:0] in_src_mac, // Source MAC
	input wire logic [MAC_W-1:0] in_dst_mac, // Destination MAC
	input wire logic in_rsrv_nonzero, // Reserved bytes flag
	input wire logic [1:0] port_domain_cfg [NP], // Domain select
	input wire logic [NP-1:0] port_stamp_en, // Stamping enable
	input wire logic [MAC_W-1:0] port_timing_smac [NP], // Port SMAC
	input wire logic [1:0] port_domain [NP], // Effective domain
	input wire logic [NP-1:0] reserved_nonzero_sticky, // Sticky flags
	input wire logic out_valid, // Result pulse
	input wire logic [MAC_W-1:0] out_dst_mac, // Rewritten DMAC
	input wire logic [MAC_W-1:0] out_src_mac, // Rewritten SMAC
	input wire logic [1:0] out_stamp_cmd, // Stamp command
	input wire logic out_auto_response, // Delay response flag
	input wire logic out_seq_insert // Sequence replaced
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////
	// Acceptance and answer timing
	logic acc;
	assign acc = in_valid && in_ready;

	chk_answer_latency: assert property (acc |=> out_valid)
		else $error("no result one cycle after accept");
	chk_no_spurious: assert property (!acc |=> !out_valid)
		else $error("result without accept");
	// Enabled tx port passes the stamping command through
	chk_stamp_cmd: assert property (acc && in_tx_port < NP &&
		port_stamp_en[in_tx_port] |=> out_stamp_cmd == $past(in_action[1:0]))
		else $error("stamp command not passed");
	chk_dmac_copy: assert property (acc && in_action[6]
		|=> out_dst_mac == $past(in_src_mac))
		else $error("source not copied to destination");
	chk_dmac_keep: assert property (acc && !in_action[6]
		|=> out_dst_mac == $past(in_dst_mac))
		else $error("destination changed");
	chk_smac_cfg: assert property (acc && in_action[7] && in_tx_port < NP
		|=> out_src_mac == port_timing_smac[$past(in_tx_port)])
		else $error("port source address not used");
	chk_auto_resp: assert property (acc
		|=> out_auto_response == ($past(in_action[5:4]) >= 2'h2))
		else $error("delay response flag wrong");
	chk_seq_insert: assert property (acc && in_action[5:4] == 2'h1
		|=> out_seq_insert)
		else $error("sequence not inserted");
	chk_twostep_gap: assert property (acc && in_action[1:0] == 2'h2
		|=> !in_ready)
		else $error("accept right after two-step");
	// Domain code 3 falls back to domain zero; port 4 is given that code
	chk_domain_map: assert property (!$past(sys_rst) |->
		port_domain[4] == (($past(port_domain_cfg[4]) == 2'h3) ?
		2'h0 : $past(port_domain_cfg[4])))
		else $error("port domain wrong");
	// Flag of the receive port is set at the accepting edge
	chk_rsrv_sticky: assert property (acc && in_rsrv_nonzero &&
		in_rx_port < NP |=> reserved_nonzero_sticky[$past(in_rx_port)])
		else $error("reserved sticky not set");

	cov_twostep: cover property (acc && in_action[1:0] == 2'h2);
	cov_seq: cover property (acc && in_action[5:4] == 2'h1);
	cov_refuse: cover property (in_valid && !in_ready);
endmodule : ptpfr_rewrite_sva

bind ptpfr_rewrite ptpfr_rewrite_sva #(.NP(NP), .PW(PW)) ptpfr_rewrite_sva_i (.*);

//--- dv/ptpfr_link_partner.sv
// Frame source standing in for the link side of the rewriter
`timescale 1ns/100ps
module ptpfr_link_partner
(
	input wire logic clock, // Core clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic send, // Offer one descriptor
	input wire logic [7:0] act, // Action to offer
	input wire logic [3:0] tx, // Transmit port to offer
	input wire logic [47:0] src, // Source MAC to offer
	input wire logic [47:0] dst, // Destination MAC to offer
	input wire logic in_ready, // Block accepts
	output logic in_valid, // Descriptor offered
	output logic [7:0] in_action, // Offered action
	output logic [3:0] in_tx_port, // Offered port
	output logic [47:0] in_src_mac, // Offered source
	output logic [47:0] in_dst_mac // Offered destination
);
	// Hold the offer until taken; idle fields toggle so stale values
	// never look valid
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			in_valid <= 1'b0;
			{in_action, in_tx_port, in_src_mac, in_dst_mac} <= '0;
		end
		else if (in_valid && in_ready)
			in_valid <= 1'b0;
		else if (send && !in_valid)
		begin
			in_valid <= 1'b1;
			{in_action, in_tx_port, in_src_mac, in_dst_mac} <= {act, tx, src, dst};
		end
		else if (!in_valid)
			{in_action, in_tx_port, in_src_mac, in_dst_mac} <=
				~{in_action, in_tx_port, in_src_mac, in_dst_mac};
	end
endmodule : ptpfr_link_partner

//--- dv/tb.sv
// Self-checking bench for the timing frame rewrite block
`timescale 1ns/100ps
module tb
	import ptpfr_pkg::*;
;
	localparam logic [47:0] S = 48'h1111_2222_3333;
	localparam logic [47:0] D = 48'h4444_5555_6666;
	localparam logic [31:0] TXS = 32'haaaa_0001;
	localparam logic [31:0] RXS = 32'h5555_0002;
	typedef struct {
		logic [7:0] a;
		logic [3:0] tx;
		logic [47:0] d, s, c;
		logic [1:0] cmd;
		logic au;
	} ptpfr_row_t;
	logic clock, sys_rst, in_valid, in_ready, in_rsrv_nonzero, in_is_udp;
	logic cpu_vp_stamp_en, twostep_fifo_control, seq_wr_en, out_valid, send;
	logic twostep_value_valid, out_seq_insert, out_tod_insert;
	logic out_auto_response, out_cksum_update;
	logic [7:0] in_action, in_hdr_stamp, seq_idx, p_act;
	logic [3:0] in_rx_port, in_tx_port, out_tx_port, p_tx;
	logic [47:0] in_src_mac, in_dst_mac, in_corr, in_rx_time, tod_now;
	logic [47:0] out_dst_mac, out_src_mac, out_corr, out_origin_time;
	logic [47:0] port_timing_smac [11];
	logic [31:0] in_tx_stamp, in_rx_stamp;
	logic [1:0] port_domain_cfg [11], port_domain [11], cpu_vp_domain_cfg;
	logic [1:0] cpu_virtual_port_timing_mode, out_stamp_cmd, out_domain;
	logic [10:0] port_stamp_en, udp_checksum_update_cfg, reserved_nonzero_clr;
	logic [10:0] correction_overflow_clr, reserved_nonzero_sticky;
	logic [10:0] correction_overflow_sticky;
	logic [15:0] egress_path_delay [11], ingress_path_delay_one [11];
	logic [15:0] ingress_path_delay_two [11], seq_wr_data, seq_rd_data, out_seq;
	logic [36:0] twostep_fifo_value;
	int err_count, checked, cycles;
	// Port 7 stamping is off, so its row expects no command
	ptpfr_row_t rows [9] = '{
		'{8'h01, 4'h1, D, S, 48'h0, 2'h1, 1'b0},
		'{8'h46, 4'h2, S, S, 48'h0, 2'h2, 1'b0},
		'{8'h83, 4'h3, D, 48'h0a00_0000_0003, 48'h0, 2'h3, 1'b0},
		'{8'h20, 4'h4, D, S, 48'h0, 2'h0, 1'b1},
		'{8'h31, 4'h5, D, S, 48'h777, 2'h1, 1'b1},
		'{8'h05, 4'h1, D, S, 48'h101, 2'h1, 1'b0},
		'{8'h09, 4'h1, D, S, 48'h200, 2'h1, 1'b0},
		'{8'h0d, 4'h6, D, S, 48'h300, 2'h1, 1'b0},
		'{8'hc1, 4'h7, S, 48'h0a00_0000_0007, 48'h0, 2'h0, 1'b0}};

	ptpfr_rewrite ptpfr_rewrite_i (.*);
	ptpfr_link_partner ptpfr_link_partner_i (.clock(clock), .sys_rst(sys_rst),
		.send(send), .act(p_act), .tx(p_tx), .src(S), .dst(D),
		.in_ready(in_ready), .in_valid(in_valid), .in_action(in_action),
		.in_tx_port(in_tx_port), .in_src_mac(in_src_mac),
		.in_dst_mac(in_dst_mac));

	////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			err_count++;
			tally_and_finish;
		end
	end

	task automatic chk(input string nm, input logic [63:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Offer one descriptor and wait for its result pulse
	task automatic send_desc(input logic [7:0] a, input logic [3:0] tx);
		int n;
		@(posedge clock);
		p_act <= a;
		p_tx <= tx;
		send <= 1'b1;
		@(posedge clock);
		send <= 1'b0;
		for (n = 0; n < 30 && out_valid !== 1'b1; n++)
			@(posedge clock) #1;
	endtask : send_desc

	task automatic pop;
		@(posedge clock);
		twostep_fifo_control <= 1'b1;
		@(posedge clock);
		twostep_fifo_control <= 1'b0;
		#1;
	endtask : pop

	task tally_and_finish;
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		{sys_rst, in_is_udp, cpu_vp_stamp_en} = 3'b111;
		{in_rsrv_nonzero, twostep_fifo_control, seq_wr_en, send} = '0;
		{in_hdr_stamp, seq_idx, p_act, p_tx, seq_wr_data} = '0;
		{in_rx_port, in_corr, cpu_vp_domain_cfg} = '0;
		{in_rx_time, tod_now} = {48'h777, 48'h9_0000};
		{in_tx_stamp, in_rx_stamp} = {TXS, RXS};
		{port_stamp_en, udp_checksum_update_cfg} = {11'h77f, 11'h0};
		{reserved_nonzero_clr, correction_overflow_clr} = '0;
		foreach (port_domain_cfg[i])
		begin
			port_domain_cfg[i] = 2'h0;
			egress_path_delay[i] = 16'h0100 + 16'(i);
			ingress_path_delay_one[i] = 16'h0200 + 16'(i);
			ingress_path_delay_two[i] = 16'h0300 + 16'(i);
			port_timing_smac[i] = 48'h0a00_0000_0000 + 48'(i);
		end
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock) #1;
		chk("domain0", port_domain[0], 2'h0);
		chk("domain10", port_domain[10], 2'h0);
		foreach (rows[i])
		begin
			send_desc(rows[i].a, rows[i].tx);
			chk("dmac", out_dst_mac, rows[i].d);
			chk("smac", out_src_mac, rows[i].s);
			chk("corr", out_corr, rows[i].c);
			chk("cmd", out_stamp_cmd, rows[i].cmd);
			chk("auto", out_auto_response, rows[i].au);
			chk("tod", out_tod_insert, rows[i].cmd == 2'h3);
			chk("otime", out_origin_time, tod_now);
			chk("txport", out_tx_port, rows[i].tx);
		end
		// Sequence entry handed out, then bumped
		@(posedge clock);
		{seq_idx, in_hdr_stamp, seq_wr_en, seq_wr_data} <= {16'h0505, 17'h100fe};
		@(posedge clock);
		seq_wr_en <= 1'b0;
		send_desc(8'h10, 4'h1);
		chk("seq", {out_seq_insert, out_seq}, 17'h100fe);
		send_desc(8'h10, 4'h1);
		chk("seq2", out_seq, 16'h00ff);
		repeat (2) @(posedge clock) #1;
		chk("seqrd", seq_rd_data, 16'h0100);
		// Checksum refresh, then disabled port with overflowing correction
		send_desc(8'h05, 4'h1);
		chk("cksum", out_cksum_update, 1'b1);
		@(posedge clock);
		{udp_checksum_update_cfg, in_corr} <= {11'h002, 48'h7fff_ffff_fff0};
		send_desc(8'h05, 4'h1);
		chk("cksum_off", out_cksum_update, 1'b0);
		chk("sat", out_corr, CORR_SAT);
		@(posedge clock) #1;
		chk("ovf", correction_overflow_sticky[1], 1'b1);
		// Reserved bytes sticky, then its clear
		@(posedge clock);
		in_rsrv_nonzero <= 1'b1;
		send_desc(8'h00, 4'h1);
		@(posedge clock);
		in_rsrv_nonzero <= 1'b0;
		#1;
		chk("rsrv", reserved_nonzero_sticky[0], 1'b1);
		@(posedge clock);
		{reserved_nonzero_clr, correction_overflow_clr} <= {11'h001, 11'h002};
		@(posedge clock);
		{reserved_nonzero_clr, correction_overflow_clr} <= '0;
		@(posedge clock) #1;
		chk("rsrv_clr", reserved_nonzero_sticky[0], 1'b0);
		chk("ovf_clr", correction_overflow_sticky[1], 1'b0);
		// Domain selection for physical and CPU ports
		@(posedge clock);
		{port_domain_cfg[3], port_domain_cfg[4], cpu_vp_domain_cfg} <= 6'h2d;
		repeat (2) @(posedge clock) #1;
		chk("dom3", port_domain[3], 2'h2);
		chk("dom4", port_domain[4], 2'h0);
		chk("cpudom", cpu_virtual_port_timing_mode, 2'h1);
		// CPU port keeps its own enable and domain
		send_desc(8'h01, 4'hc);
		chk("cpucmd", out_stamp_cmd, 2'h1);
		chk("cpuodom", out_domain, 2'h1);
		send_desc(8'h00, 4'h3);
		chk("odom3", out_domain, 2'h2);
		// Fill the stamp queue past its margin, then drain it
		send_desc(8'h02, 4'h8);
		send_desc(8'h02, 4'h9);
		repeat (3) @(posedge clock) #1;
		chk("full", in_ready, 1'b0);
		pop;
		chk("pop1", {twostep_value_valid, twostep_fifo_value},
			{2'h3, 4'h2, TXS});
		pop;
		chk("pop2", {twostep_value_valid, twostep_fifo_value},
			{2'h2, 4'h0, RXS});
		repeat (5) pop;
		chk("empty", {twostep_value_valid, twostep_fifo_value}, 38'h0);
		repeat (3) @(posedge clock) #1;
		chk("ready", in_ready, 1'b1);
		tally_and_finish;
	end
endmodule : tb
